// *** logic/rpt_pkg.sv ***
`default_nettype none
package rpt_pkg;
	// Telegram geometry, byte offsets
	localparam int unsigned TEL_BYTES = 28;
	localparam logic [4:0] TEL_LAST_IDX = 5'h1b;
	localparam int unsigned OFF_ID = 0;
	localparam int unsigned OFF_STAT = 2;
	localparam int unsigned OFF_CMD = 3;
	localparam int unsigned OFF_MAN_ID = 4;
	localparam int unsigned OFF_MAN_UID = 10;
	localparam int unsigned OFF_READ_ID = 18;
	localparam int unsigned OFF_FAULT = 24;
	// Status byte bits toward the controller
	localparam int unsigned ST_RESET_REQ = 0;
	localparam int unsigned ST_READ_ERR = 2;
	localparam int unsigned ST_WAIT_FB = 4;
	localparam int unsigned ST_PARITY = 6;
	localparam logic [7:0] ST_RSV_MASK = 8'haa;
	// Host command byte bits
	localparam int unsigned CMD_RESET = 0;
	localparam int unsigned CMD_READ = 1;
	localparam int unsigned CMD_MATCH = 2;
	localparam int unsigned CMD_NOMATCH = 3;
	// Fill characters
	localparam logic [7:0] ASCII_DASH = 8'h2d;
	localparam logic [7:0] ASCII_X = 8'h78;
	// Network defaults
	localparam logic [15:0] DEF_TCP_PORT = 16'h2715;
	localparam logic [31:0] DEF_IP_ADDR = 32'hc0a80041;
	localparam logic [31:0] DEF_NET_MASK = 32'hffffff00;
	// Buffer entry: last flag above data byte
	localparam int unsigned BUF_W = 9;
	typedef enum logic [4:0] {
		RPT_IDLE = 5'h01,
		RPT_WAIT_TRIG = 5'h02,
		RPT_CAPTURE = 5'h04,
		RPT_ERROR = 5'h08,
		RPT_WAIT_FB = 5'h10
	} rpt_state_t;
endpackage
`default_nettype wire

// *** logic/rpt_buf_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface rpt_buf_if;
	import rpt_pkg::*;
	logic in_valid;
	logic in_ready;
	logic [BUF_W-1:0] in_data;
	logic out_valid;
	logic out_ready;
	logic [BUF_W-1:0] out_data;
	modport fill (output in_valid, output in_data, input in_ready,
		input out_valid, input out_data, output out_ready);
	modport store (input in_valid, input in_data, output in_ready,
		output out_valid, output out_data, input out_ready);
endinterface
`default_nettype wire

// *** logic/rpt_buf2.sv ***
`timescale 1ns/1ps
`default_nettype none
module rpt_buf2 import rpt_pkg::*; (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// Buffer ports
	rpt_buf_if.store bif
);
	logic [BUF_W-1:0] head_ff;
	logic [BUF_W-1:0] tail_ff;
	logic [1:0] cnt_ff;
	logic push;
	logic pop;

	// Two entries; a full buffer takes no push even while it pops, so a one-cycle hiccup stalls a full-rate framer one cycle
	assign bif.in_ready = (cnt_ff != 2'h2);
	assign bif.out_valid = (cnt_ff != 2'h0);
	assign bif.out_data = head_ff;
	assign push = bif.in_valid && bif.in_ready;
	assign pop = bif.out_valid && bif.out_ready;

	// Fill level
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			cnt_ff <= 2'h0;
		end else if (push && !pop) begin
			cnt_ff <= cnt_ff + 2'h1;
		end else if (pop && !push) begin
			cnt_ff <= cnt_ff - 2'h1;
		end
	end

	// Head word, registered read data
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			head_ff <= '0;
		end else if (pop && cnt_ff == 2'h2) begin
			head_ff <= tail_ff;
		end else if (push && (cnt_ff == 2'h0 || (pop && cnt_ff == 2'h1))) begin
			head_ff <= bif.in_data;
		end
	end

	// Second entry
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			tail_ff <= '0;
		end else if (push && !pop && cnt_ff == 2'h1) begin
			tail_ff <= bif.in_data;
		end
	end
endmodule
`default_nettype wire

// *** logic/rpt_status_telegram.sv ***
`timescale 1ns/1ps
`default_nettype none
module rpt_status_telegram import rpt_pkg::*; (
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic RESETN,
	// Received host telegram tail
	input wire logic HOST_VALID,
	input wire logic [15:0] HOST_ID,
	input wire logic [7:0] HOST_CMD,
	// Capture configuration and trigger
	input wire logic CFG_WAIT_TRIGGER,
	input wire logic TRIGGER,
	output logic CAPTURE_REQ,
	// Decoder result
	input wire logic DECODE_DONE,
	input wire logic DECODE_OK,
	input wire logic [47:0] DECODE_ID,
	input wire logic DECODE_PARITY,
	// Manual entry
	input wire logic MANUAL_VALID,
	input wire logic [47:0] MANUAL_ID,
	input wire logic [63:0] MANUAL_UID,
	// Device conditions
	input wire logic RESET_REQUEST,
	input wire logic [31:0] FAULT_CODE,
	output logic ERROR_LED,
	// Network settings
	input wire logic CFG_PORT_WE,
	input wire logic [15:0] CFG_PORT,
	output logic [15:0] LISTEN_PORT,
	output logic [31:0] DEVICE_IP,
	output logic [31:0] NET_MASK,
	// Outgoing byte stream
	output logic TX_VALID,
	output logic [7:0] TX_DATA,
	output logic TX_LAST,
	input wire logic TX_READY
);
	rpt_state_t state_ff;
	rpt_state_t nxt_state;
	logic [15:0] host_id_ff;
	logic [7:0] host_cmd_ff;
	logic err_ff, wait_ff, parity_ff, manual_ff, capture_ff, pend_ff, busy_ff;
	logic [47:0] read_id_ff;
	logic [47:0] man_id_ff;
	logic [63:0] man_uid_ff;
	logic [15:0] port_ff;
	logic [4:0] byte_cnt_ff;
	logic [8*TEL_BYTES-1:0] frame_ff;
	logic [8*TEL_BYTES-1:0] snap;
	logic [7:0] stat_byte;
	logic active, read_req, close_req, start, push, send_evt;
	rpt_buf_if bif ();

	rpt_buf2 u_buf (
		.clk_sys(CLK_SYS),
		.resetn(RESETN),
		.bif(bif.store)
	);

	// Command decode; spare byte is not used by the host
	assign active = (state_ff != RPT_IDLE);
	assign read_req = HOST_VALID && HOST_CMD[CMD_READ];
	assign close_req = HOST_VALID && (HOST_CMD[CMD_RESET] || HOST_CMD[CMD_MATCH]
		|| HOST_CMD[CMD_NOMATCH]);

	// Cycle sequencer; a close outranks every other event
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			RPT_IDLE: begin
				if (read_req && !close_req) begin
					nxt_state = CFG_WAIT_TRIGGER ? RPT_WAIT_TRIG : RPT_CAPTURE;
				end
			end
			RPT_WAIT_TRIG: begin
				if (TRIGGER) begin
					nxt_state = RPT_CAPTURE;
				end
			end
			RPT_CAPTURE: begin
				if (DECODE_DONE) begin
					nxt_state = DECODE_OK ? RPT_WAIT_FB : RPT_ERROR;
				end
			end
			RPT_ERROR: begin
				if (MANUAL_VALID) begin
					nxt_state = RPT_WAIT_FB;
				end else if (TRIGGER) begin
					nxt_state = RPT_CAPTURE;
				end
			end
			RPT_WAIT_FB: nxt_state = RPT_WAIT_FB;
			default: nxt_state = RPT_IDLE;
		endcase
		if (close_req) begin
			nxt_state = RPT_IDLE;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			state_ff <= RPT_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Capture strobe on every entry into capture
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			capture_ff <= 1'b0;
		end else begin
			capture_ff <= (nxt_state == RPT_CAPTURE) && (state_ff != RPT_CAPTURE);
		end
	end

	// Host identifier and command mirror
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			host_id_ff <= 16'h0000;
			host_cmd_ff <= 8'h00;
		end else if (HOST_VALID) begin
			host_id_ff <= HOST_ID;
			host_cmd_ff <= HOST_CMD;
		end
	end

	// Result and status flags; a stray read request touches none of them
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			err_ff <= 1'b0;
			wait_ff <= 1'b0;
			manual_ff <= 1'b0;
			parity_ff <= 1'b0;
			read_id_ff <= '0;
			man_id_ff <= '0;
			man_uid_ff <= '0;
		end else if (close_req) begin
			err_ff <= 1'b0;
			wait_ff <= 1'b0;
			manual_ff <= 1'b0;
		end else if (state_ff == RPT_CAPTURE && DECODE_DONE) begin
			err_ff <= !DECODE_OK;
			wait_ff <= DECODE_OK;
			if (DECODE_OK) begin
				read_id_ff <= DECODE_ID;
				parity_ff <= DECODE_PARITY;
			end
		end else if (state_ff == RPT_ERROR && MANUAL_VALID) begin
			err_ff <= 1'b0;
			wait_ff <= 1'b1;
			manual_ff <= 1'b1;
			man_id_ff <= MANUAL_ID;
			man_uid_ff <= MANUAL_UID;
		end
	end

	assign ERROR_LED = err_ff;

	// Configurable listening port, fixed address and mask
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			port_ff <= DEF_TCP_PORT;
		end else if (CFG_PORT_WE) begin
			port_ff <= CFG_PORT;
		end
	end

	assign LISTEN_PORT = port_ff;
	assign DEVICE_IP = DEF_IP_ADDR;
	assign NET_MASK = DEF_NET_MASK;

	// Telegram image; byte k of each field sits at field offset plus k
	always_comb begin
		stat_byte = 8'h00;
		stat_byte[ST_RESET_REQ] = RESET_REQUEST;
		stat_byte[ST_READ_ERR] = err_ff;
		stat_byte[ST_WAIT_FB] = wait_ff;
		stat_byte[ST_PARITY] = parity_ff;
		snap = '0;
		snap[OFF_ID*8 +: 16] = host_id_ff;
		snap[OFF_STAT*8 +: 8] = stat_byte;
		snap[OFF_CMD*8 +: 8] = host_cmd_ff;
		snap[OFF_MAN_ID*8 +: 48] = manual_ff ? man_id_ff : {6{ASCII_DASH}};
		snap[OFF_MAN_UID*8 +: 64] = manual_ff ? man_uid_ff : {8{ASCII_DASH}};
		snap[OFF_READ_ID*8 +: 48] = manual_ff ? {6{ASCII_X}} : read_id_ff;
		snap[OFF_FAULT*8 +: 32] = FAULT_CODE;
	end

	// Send requests: host telegram, result, manual entry; set wins over clear
	assign send_evt = HOST_VALID || (state_ff == RPT_CAPTURE && DECODE_DONE)
		|| (state_ff == RPT_ERROR && MANUAL_VALID);
	assign start = pend_ff && !busy_ff;
	assign push = bif.in_valid && bif.in_ready;

	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			pend_ff <= 1'b0;
		end else begin
			pend_ff <= send_evt || (pend_ff && !start);
		end
	end

	// Framer: snapshot once, then shift bytes out under back-pressure
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			busy_ff <= 1'b0;
			byte_cnt_ff <= 5'h00;
			frame_ff <= '0;
		end else if (start) begin
			busy_ff <= 1'b1;
			byte_cnt_ff <= 5'h00;
			frame_ff <= snap;
		end else if (push) begin
			busy_ff <= (byte_cnt_ff != TEL_LAST_IDX);
			byte_cnt_ff <= byte_cnt_ff + 5'h01;
			frame_ff <= frame_ff >> 8;
		end
	end

	assign bif.in_valid = busy_ff;
	assign bif.in_data = {byte_cnt_ff == TEL_LAST_IDX, frame_ff[7:0]};
	assign bif.out_ready = TX_READY;
	assign TX_VALID = bif.out_valid;
	assign TX_DATA = bif.out_data[7:0];
	assign TX_LAST = bif.out_data[8];
	assign CAPTURE_REQ = capture_ff;

	// Checks
	property p_len;
		@(posedge CLK_SYS) disable iff (!RESETN)
		start |=> busy_ff ##[27:100] !busy_ff;
	endproperty
	property p_last;
		@(posedge CLK_SYS) disable iff (!RESETN)
		(push && bif.in_data[8]) |-> byte_cnt_ff == TEL_LAST_IDX ##1 !busy_ff;
	endproperty
	a_last: assert property (p_last) else $error("last byte not at index 27");
	property p_id_echo;
		@(posedge CLK_SYS) disable iff (!RESETN)
		start |=> frame_ff[15:0] == $past(host_id_ff);
	endproperty
	a_id_echo: assert property (p_id_echo) else $error("identifier not echoed");
	property p_rsv;
		@(posedge CLK_SYS) disable iff (!RESETN)
		start |=> (frame_ff[OFF_STAT*8 +: 8] & ST_RSV_MASK) == 8'h00
			&& frame_ff[OFF_STAT*8+ST_WAIT_FB] == $past(wait_ff);
	endproperty
	a_rsv: assert property (p_rsv) else $error("status byte wrong");
	property p_cmd_echo;
		@(posedge CLK_SYS) disable iff (!RESETN)
		HOST_VALID ##1 start |=> frame_ff[OFF_CMD*8 +: 8] == $past(HOST_CMD, 2);
	endproperty
	a_cmd_echo: assert property (p_cmd_echo) else $error("command not echoed");
	property p_dash;
		@(posedge CLK_SYS) disable iff (!RESETN)
		(start && !manual_ff) |=> frame_ff[OFF_MAN_ID*8 +: 112] == {14{ASCII_DASH}};
	endproperty
	a_dash: assert property (p_dash) else $error("manual field not dashes");
	property p_xfill;
		@(posedge CLK_SYS) disable iff (!RESETN)
		(start && manual_ff) |=> frame_ff[OFF_READ_ID*8 +: 48] == {6{ASCII_X}};
	endproperty
	a_xfill: assert property (p_xfill) else $error("read id not x after manual");
	property p_ok;
		@(posedge CLK_SYS) disable iff (!RESETN)
		(state_ff == RPT_CAPTURE && DECODE_DONE && DECODE_OK && !close_req)
			|=> wait_ff && pend_ff ##[1:2] busy_ff;
	endproperty
	a_ok: assert property (p_ok) else $error("success not reported");
	property p_fail;
		@(posedge CLK_SYS) disable iff (!RESETN)
		(state_ff == RPT_CAPTURE && DECODE_DONE && !DECODE_OK && !close_req)
			|=> ERROR_LED && state_ff == RPT_ERROR && !wait_ff;
	endproperty
	a_fail: assert property (p_fail) else $error("failure not reported");
	property p_manual;
		@(posedge CLK_SYS) disable iff (!RESETN)
		(state_ff == RPT_ERROR && MANUAL_VALID && !close_req)
			|=> wait_ff && !err_ff && manual_ff;
	endproperty
	a_manual: assert property (p_manual) else $error("manual entry not taken");
	property p_close;
		@(posedge CLK_SYS) disable iff (!RESETN)
		close_req |=> state_ff == RPT_IDLE && !wait_ff && !err_ff;
	endproperty
	a_close: assert property (p_close) else $error("close did not idle");
	property p_ignore;
		@(posedge CLK_SYS) disable iff (!RESETN)
		(read_req && !close_req && state_ff == RPT_WAIT_FB)
			|=> $stable(wait_ff) && $stable(err_ff) && state_ff == RPT_WAIT_FB;
	endproperty
	a_ignore: assert property (p_ignore) else $error("read during cycle acted");
	property p_start;
		@(posedge CLK_SYS) disable iff (!RESETN)
		(state_ff == RPT_IDLE && read_req && !close_req && !CFG_WAIT_TRIGGER)
			|=> state_ff == RPT_CAPTURE && CAPTURE_REQ;
	endproperty
	a_start: assert property (p_start) else $error("read did not capture");
	property p_port;
		@(posedge CLK_SYS) disable iff (!RESETN)
		CFG_PORT_WE |=> LISTEN_PORT == $past(CFG_PORT);
	endproperty
	a_port: assert property (p_port) else $error("port not loaded");
	c_len: cover property (p_len);
	c_ok: cover property (@(posedge CLK_SYS) disable iff (!RESETN)
		state_ff == RPT_CAPTURE ##1 state_ff == RPT_WAIT_FB ##[1:50] state_ff == RPT_IDLE);
	c_manual: cover property (@(posedge CLK_SYS) disable iff (!RESETN)
		state_ff == RPT_ERROR ##1 state_ff == RPT_WAIT_FB);
	c_stall: cover property (@(posedge CLK_SYS) disable iff (!RESETN)
		busy_ff && !bif.in_ready);
endmodule
`default_nettype wire

// *** bench/rpt_plc_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module rpt_plc_model import rpt_pkg::*; (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// Stream from the device
	input wire logic stall,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_last,
	output logic tx_ready,
	// Last whole telegram, byte k at [8k+:8]
	output logic [223:0] frame,
	output int frames,
	output int len_errs
);
	logic [215:0] part_ff;
	logic [4:0] idx_ff;
	logic tog_ff;
	// Stall every other cycle, so a word dropped under backpressure shows
	assign tx_ready = !stall || tog_ff;
	// Collect bytes and count frames of the wrong length
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			part_ff <= '0;
			idx_ff <= 5'h00;
			tog_ff <= 1'b0;
			frame <= '0;
			frames <= 0;
			len_errs <= 0;
		end else begin
			tog_ff <= !tog_ff;
			if (tx_valid && tx_ready) begin
				if (tx_last) begin
					frame <= {tx_data, part_ff};
					frames <= frames + 1;
					idx_ff <= 5'h00;
					if (idx_ff != TEL_LAST_IDX) len_errs <= len_errs + 1;
				end else if (idx_ff == TEL_LAST_IDX) begin
					len_errs <= len_errs + 1;
				end else begin
					part_ff[8*idx_ff+:8] <= tx_data;
					idx_ff <= idx_ff + 5'h01;
				end
			end
		end
	end
endmodule
`default_nettype wire

// *** bench/rpt_status_telegram_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module rpt_status_telegram_tb import rpt_pkg::*; ;
	logic clk_sys, resetn, host_valid, wait_trig, trigger, cap_req, dec_done, dec_ok;
	logic dec_par, man_valid, rst_req, err_led, port_we, tx_valid, tx_last, tx_ready, stall;
	logic [15:0] host_id, cfg_port, listen_port;
	logic [7:0] host_cmd, tx_data;
	logic [47:0] dec_id, man_id;
	logic [63:0] man_uid;
	logic [31:0] fault, dev_ip, net_mask;
	logic [223:0] fr;
	int frames, len_errs, caps, failures, samples_checked;

	rpt_status_telegram i_dut (.CLK_SYS(clk_sys), .RESETN(resetn),
		.HOST_VALID(host_valid), .HOST_ID(host_id), .HOST_CMD(host_cmd),
		.CFG_WAIT_TRIGGER(wait_trig), .TRIGGER(trigger), .CAPTURE_REQ(cap_req),
		.DECODE_DONE(dec_done), .DECODE_OK(dec_ok), .DECODE_ID(dec_id),
		.DECODE_PARITY(dec_par), .MANUAL_VALID(man_valid), .MANUAL_ID(man_id),
		.MANUAL_UID(man_uid), .RESET_REQUEST(rst_req), .FAULT_CODE(fault),
		.ERROR_LED(err_led), .CFG_PORT_WE(port_we), .CFG_PORT(cfg_port),
		.LISTEN_PORT(listen_port), .DEVICE_IP(dev_ip), .NET_MASK(net_mask),
		.TX_VALID(tx_valid), .TX_DATA(tx_data), .TX_LAST(tx_last), .TX_READY(tx_ready));
	rpt_plc_model i_plc (.clk_sys(clk_sys), .resetn(resetn), .stall(stall),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
		.frame(fr), .frames(frames), .len_errs(len_errs));

	// Clock and capture pulse counter
	always #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) if (cap_req === 1'b1) caps++;

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Inputs always move 1 ns after the edge
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	// Bounded wait for one more whole telegram
	task automatic await_frame(input int n0);
		int t;
		t = 0;
		while (frames == n0 && t < 600) begin
			tick(1);
			t++;
		end
		chk(frames - n0, 1);
	endtask
	task automatic host(input logic [15:0] id, input logic [7:0] cmd);
		int n;
		n = frames;
		host_id = id;
		host_cmd = cmd;
		host_valid = 1'b1;
		tick(1);
		host_valid = 1'b0;
		await_frame(n);
	endtask
	task automatic decode(input logic ok);
		int n;
		n = frames;
		dec_ok = ok;
		dec_done = 1'b1;
		tick(1);
		dec_done = 1'b0;
		await_frame(n);
	endtask
	// Retry or start by trigger; expects one capture pulse
	task automatic trig();
		int c;
		c = caps;
		trigger = 1'b1;
		tick(1);
		trigger = 1'b0;
		tick(3);
		chk(caps - c, 1);
	endtask
	// Whole telegram against the expected fields; parity bit masked off
	task automatic frame_chk(input logic [15:0] id, input logic [7:0] st,
		input logic [7:0] cmd, input logic man, input logic [47:0] rid);
		logic [111:0] m;
		m = {man_uid, man_id};
		chk(fr[15:0], id);
		chk(fr[23:16] & 8'hbf, st);
		chk(fr[31:24], cmd);
		for (int k = 0; k < 14; k++) chk(fr[32+8*k+:8], man ? m[8*k+:8] : ASCII_DASH);
		chk(fr[191:144], man ? {6{8'h78}} : rid);
		chk(fr[223:192], fault);
		chk(len_errs, 0);
	endtask

	task automatic t_reset();
		chk(tx_valid, 0);
		chk(err_led, 0);
		chk(listen_port, 16'h2715);
		chk(dev_ip, 32'hc0a80041);
		chk(net_mask, 32'hffffff00);
		cfg_port = 16'h1f90;
		port_we = 1'b1;
		tick(1);
		port_we = 1'b0;
		tick(1);
		chk(listen_port, 16'h1f90);
		$display("test reset done");
	endtask
	task automatic t_success();
		int c;
		c = caps;
		rst_req = 1'b1;
		host(16'ha55a, 8'h02);
		chk(caps - c, 1);
		frame_chk(16'ha55a, 8'h01, 8'h02, 1'b0, 48'h0);
		dec_id = 48'h363534333231;
		dec_par = 1'b1;
		decode(1'b1);
		frame_chk(16'ha55a, 8'h11, 8'h02, 1'b0, dec_id);
		chk(fr[22], 1);
		c = caps;
		host(16'h0102, 8'h02);
		frame_chk(16'h0102, 8'h11, 8'h02, 1'b0, dec_id);
		chk(caps - c, 0);
		host(16'h0304, 8'h03);
		frame_chk(16'h0304, 8'h01, 8'h03, 1'b0, dec_id);
		chk(caps - c, 0);
		rst_req = 1'b0;
		$display("test success done");
	endtask
	task automatic t_manual();
		int c;
		int n;
		c = caps;
		stall = 1'b1;
		wait_trig = 1'b1;
		host(16'h1111, 8'h02);
		chk(caps - c, 0);
		trig();
		decode(1'b0);
		frame_chk(16'h1111, 8'h04, 8'h02, 1'b0, dec_id);
		chk(err_led, 1);
		man_id = 48'h414243444546;
		man_uid = 64'h3031323334353637;
		n = frames;
		man_valid = 1'b1;
		tick(1);
		man_valid = 1'b0;
		await_frame(n);
		frame_chk(16'h1111, 8'h10, 8'h02, 1'b1, 48'h0);
		chk(err_led, 0);
		host(16'h2222, 8'h04);
		frame_chk(16'h2222, 8'h00, 8'h04, 1'b0, dec_id);
		$display("test manual done");
	endtask
	task automatic t_retry();
		wait_trig = 1'b0;
		host(16'h3333, 8'h02);
		decode(1'b0);
		trig();
		dec_id = 48'h0a0b0c0d0e0f;
		decode(1'b1);
		frame_chk(16'h3333, 8'h10, 8'h02, 1'b0, dec_id);
		host(16'h4444, 8'h08);
		frame_chk(16'h4444, 8'h00, 8'h08, 1'b0, dec_id);
		$display("test retry done");
	endtask

	task automatic conclude();
		$display("counts: %0d checked, %0d wrong", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Watchdog, far beyond the several hundred cycles the tests need
	initial begin
		repeat (50000) @(posedge clk_sys);
		failures++;
		conclude();
	end
	// Main sequence
	initial begin
		{clk_sys, resetn, host_valid, wait_trig, trigger, dec_done, dec_ok} = '0;
		{dec_par, man_valid, rst_req, port_we, stall} = '0;
		{host_id, cfg_port, host_cmd, dec_id, man_id, man_uid} = '0;
		fault = 32'h87654321;
		{caps, failures, samples_checked} = '0;
		repeat (20) @(posedge clk_sys);
		#1;
		resetn = 1'b1;
		tick(1);
		t_reset();
		t_success();
		t_manual();
		t_retry();
		conclude();
	end
endmodule
`default_nettype wire
